/* inc/ext_ctrl_defines.svh */
// Constants for the per-port extended control and status register bank.
// Assumes a 5-bit management register address and 16-bit register data.
`ifndef EXT_CTRL_DEFINES_SVH
`define EXT_CTRL_DEFINES_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_EXT_CTRL_STATUS 5'h16
`define ADDR_EXT_PHY_CTRL_ONE 5'h17

// ****************************************************************
// Field positions, extended control and status
// ****************************************************************
`define FORCE_LINK_BIT 15
`define JABBER_DIS_BIT 14
`define ECHO_DIS_BIT 13
`define HEARTBEAT_DIS_BIT 12
`define SQUELCH_HI 11
`define SQUELCH_LO 10
`define RETAIN_BIT 9
`define EOF_ERR_BIT 8
`define DISCONNECT_BIT 7
`define LINK_STATUS_BIT 6
`define CS_MODE_HI 2
`define CS_MODE_LO 1
`define BCAST_BIT 0

// ****************************************************************
// Field positions, extended PHY control one
// ****************************************************************
`define MAC_ANEG_BIT 13
`define MAC_MODE_BIT 12

// ****************************************************************
// Reset values
// ****************************************************************
`define FORCE_LINK_RST 1'h0
`define JABBER_DIS_RST 1'h0
`define ECHO_DIS_RST 1'h1
`define HEARTBEAT_DIS_RST 1'h1
`define SQUELCH_RST 2'h0
`define RETAIN_RST 1'h1
`define CS_MODE_RST 2'h0
`define BCAST_RST 1'h0
`define MAC_MODE_RST 1'h0

// ****************************************************************
// Timing
// ****************************************************************
`define STRAP_SETTLE_CYCLES 3'h4

`endif

/* inc/ext_ctrl_pkg.sv */
// Types shared by the extended control and status register bank.
// Assumes nothing of its surroundings.
package ext_ctrl_pkg;

  typedef enum logic [1:0] {
    SQUELCH_NORMAL = 2'b00,
    SQUELCH_LOW = 2'b01,
    SQUELCH_HIGH = 2'b10,
    SQUELCH_RESERVED = 2'b11
  } squelch_t;

  typedef enum logic [1:0] {
    CS_RX_TX = 2'b00,
    CS_RX_TX_NONE_FD = 2'b01,
    CS_RX_ONLY = 2'b10,
    CS_RX_ONLY_NONE_FD = 2'b11
  } carrier_sense_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } strap_state_t;

  typedef struct packed {
    logic force_link;
    logic jabber_disable;
    logic echo_disable;
    logic heartbeat_test_disable;
    squelch_t squelch;
    logic retain_sticky;
    carrier_sense_mode_t cs_mode;
    logic broadcast_write;
    logic mac_aneg_enable;
    logic mac_mode_1000x;
  } port_ctrl_t;

  typedef struct packed {
    logic link_active;
    logic full_duplex;
    logic rx_active;
    logic tx_active;
    logic eof_error;
    logic disconnect;
  } line_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] phy;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } mgmt_resp_t;

endpackage

/* rtl/strap_sync.sv */
// Three-stage synchroniser for levels arriving from pins.
// Assumes the input may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Asynchronous level in, filtered level out
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= level_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change is passed on only once the last two stages agree.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      level_out <= '0;
    end else if (stage2 == stage3) begin
      level_out <= stage3;
    end
  end

endmodule

`default_nettype wire

/* rtl/carrier_sense_map.sv */
// Maps receive and transmit activity onto carrier sense for one port.
// Assumes activity and duplex come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module carrier_sense_map (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Selection and activity
  input wire ext_ctrl_pkg::carrier_sense_mode_t mode,
  input wire logic full_duplex,
  input wire logic rx_active,
  input wire logic tx_active,
  // Registered carrier sense
  output logic carrier_sense
);

  logic next_carrier_sense;

  always_comb begin
    next_carrier_sense = 1'b0;
    case (mode)
      ext_ctrl_pkg::CS_RX_TX: begin
        next_carrier_sense = full_duplex ? rx_active : (rx_active | tx_active); // [RL12] [RL13]
      end
      ext_ctrl_pkg::CS_RX_TX_NONE_FD: begin
        next_carrier_sense = full_duplex ? 1'b0 : (rx_active | tx_active); // [RL12] [RL13]
      end
      ext_ctrl_pkg::CS_RX_ONLY: begin
        next_carrier_sense = rx_active; // [RL12] [RL13]
      end
      ext_ctrl_pkg::CS_RX_ONLY_NONE_FD: begin
        next_carrier_sense = full_duplex ? 1'b0 : rx_active; // [RL12] [RL13]
      end
      default: begin
        next_carrier_sense = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      carrier_sense <= 1'b0;
    end else begin
      carrier_sense <= next_carrier_sense;
    end
  end

endmodule

`default_nettype wire

/* rtl/phy_ext_regs.sv */
// Extended control and status registers for every port of a multi-port PHY.
// Assumes an outside engine decodes management frames into single-cycle
// read and write requests on this clock, and that line-side status comes
// from logic on the same clock; only the strap pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none

`include "ext_ctrl_defines.svh"

// Behaviour
// [RL1] Register 22 decoded in each port's space.
// [RL2] Force-link bit holds link pass status.
// [RL3] Jabber-disable bit turns off jabber detection.
// [RL4] Echo-disable resets to one, suppresses echo.
// [RL5] Heartbeat-disable resets to one, disables heartbeat.
// [RL6] Two-bit squelch field selects threshold level.
// [RL7] Retention bit keeps sticky bits over soft reset.
// [RL8] Super-sticky bits always survive soft reset.
// [RL9] End-of-frame error flag set, self-clearing.
// [RL10] Disconnect flag set on link drop, self-clearing.
// [RL11] Link status bit shows link active.
// [RL12] Half duplex carrier sense per field code.
// [RL13] Full duplex carrier sense per field code.
// [RL14] Broadcast bit sends writes to every port.
// [RL15] Reads return only the addressed port.
// [RL16] Broadcast clear restores single-port writes.
// [RL17] Register 23 bit 13 strap-loaded auto-negotiation.
// [RL18] Register 23 bit 12 selects interface mode.
// [RL19] Flags clear on read, reserved read zero.
module phy_ext_regs #(
  parameter int NUM_PORTS = 4,
  parameter int BASE_PHY_ADDR = 0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,

  // Decoded management requests and registered answers
  input wire ext_ctrl_pkg::mgmt_req_t mgmt_req,
  output ext_ctrl_pkg::mgmt_resp_t mgmt_resp,

  // Software reset pulses, one per port
  input wire logic [NUM_PORTS-1:0] soft_reset,

  // Line-side status and events, one per port
  input wire ext_ctrl_pkg::line_status_t [NUM_PORTS-1:0] line_status,

  // Configuration strap pin
  input wire logic config_strap_mode,

  // Controls toward the line-side logic
  output ext_ctrl_pkg::port_ctrl_t [NUM_PORTS-1:0] port_ctrl,
  output logic [NUM_PORTS-1:0] link_pass,
  output logic [NUM_PORTS-1:0] carrier_sense,

  // Writes forwarded to the other register banks of each port
  output logic [NUM_PORTS-1:0] fwd_wr_mask,
  output logic [4:0] fwd_reg_addr,
  output logic [15:0] fwd_wdata
);

  // ****************************************************************
  // Request decode shared by all ports
  // ****************************************************************
  logic [NUM_PORTS-1:0] port_hit;
  logic [NUM_PORTS-1:0] bcast_bits;
  logic bcast_any;

  logic addr_is_ctrl_status;
  logic addr_is_phy_ctrl_one;

  logic [15:0] ctrl_status_word [NUM_PORTS];
  logic [15:0] phy_ctrl_one_word [NUM_PORTS];
  logic [15:0] next_rdata;

  assign addr_is_ctrl_status = (mgmt_req.reg_addr == `ADDR_EXT_CTRL_STATUS); // [RL1]
  assign addr_is_phy_ctrl_one = (mgmt_req.reg_addr == `ADDR_EXT_PHY_CTRL_ONE);

  // Any port with broadcast enabled turns every write into a device-wide one.
  // The bit is copied into all ports by the same broadcast, so in normal use
  // every port carries the same value.
  assign bcast_any = |bcast_bits; // [RL14] [RL16]

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // The strap is sampled only after the synchroniser has refilled following
  // reset release, so the reset itself never loads a pin value.
  logic strap_level;

  ext_ctrl_pkg::strap_state_t strap_state;
  logic [2:0] settle_count;
  logic strap_load;

  strap_sync #(
    .WIDTH(1)
  ) u_strap_sync (
    .clock(clock),
    .resetn(resetn),
    .level_in(config_strap_mode),
    .level_out(strap_level)
  );

  // A register 23 write made before the strap load has its bit 13 overwritten by it,
  // so the station must let the settle time pass first.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      strap_state <= ext_ctrl_pkg::ST_HOLD;
      settle_count <= 3'h0;
      strap_load <= 1'b0;
    end else begin
      strap_load <= 1'b0;

      case (strap_state)
        ext_ctrl_pkg::ST_HOLD: begin
          settle_count <= 3'h0;
          strap_state <= ext_ctrl_pkg::ST_SETTLE;
        end

        ext_ctrl_pkg::ST_SETTLE: begin
          settle_count <= settle_count + 3'h1;
          if (settle_count == `STRAP_SETTLE_CYCLES - 3'h1) begin
            strap_load <= 1'b1;
            strap_state <= ext_ctrl_pkg::ST_RUN;
          end
        end

        ext_ctrl_pkg::ST_RUN: begin
          strap_state <= ext_ctrl_pkg::ST_RUN;
        end

        default: begin
          strap_state <= ext_ctrl_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-port register logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      localparam logic [4:0] PORT_ADDR = 5'(BASE_PHY_ADDR + gi);

      logic wr_this;
      logic wr_ctrl_status;
      logic wr_phy_ctrl_one;
      logic rd_ctrl_status;
      logic sticky_to_default;

      ext_ctrl_pkg::port_ctrl_t ctrl;

      logic eof_error_flag;
      logic disconnect_flag;
      logic link_up;

      assign port_hit[gi] = (mgmt_req.phy == PORT_ADDR);
      // Broadcast covers every register address, so only the write path widens.
      assign wr_this = mgmt_req.wr & (port_hit[gi] | bcast_any); // [RL14] [RL16]
      assign wr_ctrl_status = wr_this & addr_is_ctrl_status; // [RL1]
      assign wr_phy_ctrl_one = wr_this & addr_is_phy_ctrl_one;
      assign rd_ctrl_status = mgmt_req.rd & port_hit[gi] & addr_is_ctrl_status; // [RL19]

      assign sticky_to_default = soft_reset[gi] & ~ctrl.retain_sticky; // [RL7]
      assign bcast_bits[gi] = ctrl.broadcast_write;

      // Sticky controls: a write in the same cycle as a soft reset wins,
      // since software issued it after asking for the reset.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          ctrl.force_link <= `FORCE_LINK_RST;
          ctrl.jabber_disable <= `JABBER_DIS_RST;
          ctrl.echo_disable <= `ECHO_DIS_RST; // [RL4]
          ctrl.heartbeat_test_disable <= `HEARTBEAT_DIS_RST; // [RL5]
          ctrl.squelch <= ext_ctrl_pkg::squelch_t'(`SQUELCH_RST);
          ctrl.cs_mode <= ext_ctrl_pkg::carrier_sense_mode_t'(`CS_MODE_RST);
          ctrl.broadcast_write <= `BCAST_RST;
        end else if (wr_ctrl_status) begin
          ctrl.force_link <= mgmt_req.wdata[`FORCE_LINK_BIT]; // [RL2]
          ctrl.jabber_disable <= mgmt_req.wdata[`JABBER_DIS_BIT]; // [RL3]
          ctrl.echo_disable <= mgmt_req.wdata[`ECHO_DIS_BIT]; // [RL4]
          ctrl.heartbeat_test_disable <= mgmt_req.wdata[`HEARTBEAT_DIS_BIT]; // [RL5]
          ctrl.squelch <= ext_ctrl_pkg::squelch_t'(mgmt_req.wdata[`SQUELCH_HI:`SQUELCH_LO]); // [RL6]
          ctrl.cs_mode <= ext_ctrl_pkg::carrier_sense_mode_t'(mgmt_req.wdata[`CS_MODE_HI:`CS_MODE_LO]);
          ctrl.broadcast_write <= mgmt_req.wdata[`BCAST_BIT]; // [RL14] [RL16]
        end else if (sticky_to_default) begin
          ctrl.force_link <= `FORCE_LINK_RST; // [RL7]
          ctrl.jabber_disable <= `JABBER_DIS_RST; // [RL7]
          ctrl.echo_disable <= `ECHO_DIS_RST; // [RL7]
          ctrl.heartbeat_test_disable <= `HEARTBEAT_DIS_RST; // [RL7]
          ctrl.squelch <= ext_ctrl_pkg::squelch_t'(`SQUELCH_RST); // [RL7]
          ctrl.cs_mode <= ext_ctrl_pkg::carrier_sense_mode_t'(`CS_MODE_RST);
          ctrl.broadcast_write <= `BCAST_RST; // [RL7]
        end
      end

      // Super-sticky retention enable: only hardware reset and writes move it.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          ctrl.retain_sticky <= `RETAIN_RST; // [RL7]
        end else if (wr_ctrl_status) begin
          ctrl.retain_sticky <= mgmt_req.wdata[`RETAIN_BIT]; // [RL7] [RL8]
        end
      end

      // Super-sticky MAC-side controls; the auto-negotiation enable takes
      // the strap once it has settled after reset.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          ctrl.mac_aneg_enable <= 1'b0;
          ctrl.mac_mode_1000x <= `MAC_MODE_RST; // [RL18]
        end else if (wr_phy_ctrl_one) begin
          ctrl.mac_aneg_enable <= mgmt_req.wdata[`MAC_ANEG_BIT]; // [RL17] [RL8]
          ctrl.mac_mode_1000x <= mgmt_req.wdata[`MAC_MODE_BIT]; // [RL18] [RL8]
        end else if (strap_load) begin
          ctrl.mac_aneg_enable <= strap_level; // [RL17]
        end
      end

      // Event flags: an event in the cycle of a clearing read still sets.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          eof_error_flag <= 1'b0;
        end else if (line_status[gi].eof_error) begin
          eof_error_flag <= 1'b1; // [RL9]
        end else if (rd_ctrl_status | soft_reset[gi]) begin
          eof_error_flag <= 1'b0; // [RL9] [RL19]
        end
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          disconnect_flag <= 1'b0;
        end else if (line_status[gi].disconnect) begin
          disconnect_flag <= 1'b1; // [RL10]
        end else if (rd_ctrl_status | soft_reset[gi]) begin
          disconnect_flag <= 1'b0; // [RL10] [RL19]
        end
      end

      // Forcing the link bypasses the integrity check, so it reads as up.
      always_ff @(posedge clock) begin
        if (!resetn) begin
          link_up <= 1'b0;
        end else begin
          link_up <= line_status[gi].link_active | ctrl.force_link; // [RL2] [RL11]
        end
      end

      carrier_sense_map u_carrier_sense_map (
        .clock(clock),
        .resetn(resetn),
        .mode(ctrl.cs_mode),
        .full_duplex(line_status[gi].full_duplex),
        .rx_active(line_status[gi].rx_active),
        .tx_active(line_status[gi].tx_active),
        .carrier_sense(carrier_sense[gi])
      );

      assign port_ctrl[gi] = ctrl;
      assign link_pass[gi] = link_up;

      // Reserved positions are left at zero in the readback words.
      always_comb begin
        ctrl_status_word[gi] = 16'h0000; // [RL19]
        ctrl_status_word[gi][`FORCE_LINK_BIT] = ctrl.force_link;
        ctrl_status_word[gi][`JABBER_DIS_BIT] = ctrl.jabber_disable;
        ctrl_status_word[gi][`ECHO_DIS_BIT] = ctrl.echo_disable;
        ctrl_status_word[gi][`HEARTBEAT_DIS_BIT] = ctrl.heartbeat_test_disable;
        ctrl_status_word[gi][`SQUELCH_HI:`SQUELCH_LO] = ctrl.squelch;
        ctrl_status_word[gi][`RETAIN_BIT] = ctrl.retain_sticky;
        ctrl_status_word[gi][`EOF_ERR_BIT] = eof_error_flag; // [RL9]
        ctrl_status_word[gi][`DISCONNECT_BIT] = disconnect_flag; // [RL10]
        ctrl_status_word[gi][`LINK_STATUS_BIT] = link_up; // [RL11]
        ctrl_status_word[gi][`CS_MODE_HI:`CS_MODE_LO] = ctrl.cs_mode;
        ctrl_status_word[gi][`BCAST_BIT] = ctrl.broadcast_write;
      end

      always_comb begin
        phy_ctrl_one_word[gi] = 16'h0000;
        phy_ctrl_one_word[gi][`MAC_ANEG_BIT] = ctrl.mac_aneg_enable;
        phy_ctrl_one_word[gi][`MAC_MODE_BIT] = ctrl.mac_mode_1000x;
      end
    end
  endgenerate

  // ****************************************************************
  // Read answer
  // ****************************************************************
  // Only the addressed port's word is selected, broadcast or not. Addresses
  // held by other banks answer zero here so their data can be ORed in.
  always_comb begin
    next_rdata = 16'h0000;

    for (int i = 0; i < NUM_PORTS; i++) begin
      if (port_hit[i] && addr_is_ctrl_status) begin
        next_rdata = ctrl_status_word[i]; // [RL15]
      end else if (port_hit[i] && addr_is_phy_ctrl_one) begin
        next_rdata = phy_ctrl_one_word[i]; // [RL15]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mgmt_resp <= '0;
    end else begin
      mgmt_resp.valid <= mgmt_req.rd;
      if (mgmt_req.rd) begin
        mgmt_resp.data <= next_rdata;
      end else begin
        mgmt_resp.data <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Write forwarding
  // ****************************************************************
  // Other banks see the same widened write one cycle later, which keeps the
  // broadcast decision in one place.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fwd_wr_mask <= '0;
      fwd_reg_addr <= 5'h00;
      fwd_wdata <= 16'h0000;
    end else begin
      if (!mgmt_req.wr) begin
        fwd_wr_mask <= '0;
      end else if (bcast_any) begin
        fwd_wr_mask <= {NUM_PORTS{1'b1}}; // [RL14]
      end else begin
        fwd_wr_mask <= port_hit; // [RL16]
      end

      fwd_reg_addr <= mgmt_req.reg_addr;
      fwd_wdata <= mgmt_req.wdata;
    end
  end

endmodule

`default_nettype wire

/* sim/mgmt_station.sv */
// Station management model that issues decoded one-cycle read and write requests.
// Assumes answers come back registered at the taking edge and are read 1 ns after it.
`timescale 1ns/1ps
`default_nettype none

module mgmt_station (
  // Clock
  input wire logic clock,
  // Requests out, answers in
  output var ext_ctrl_pkg::mgmt_req_t mgmt_req,
  input wire ext_ctrl_pkg::mgmt_resp_t mgmt_resp
);
  initial mgmt_req = '0;

  task automatic go(input logic w, input logic [4:0] p, input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1 mgmt_req = '{wr: w, rd: !w, phy: p, reg_addr: a, wdata: d};
    @(posedge clock);
    // Idle fields are inverted so that nothing can lean on a stale request.
    #1 mgmt_req = '{wr: 1'b0, rd: 1'b0, phy: ~p, reg_addr: ~a, wdata: ~d};
  endtask

  task automatic wr_reg(input logic [4:0] p, input logic [4:0] a, input logic [15:0] d);
    go(1'b1, p, a, d);
  endtask

  task automatic rd_reg(input logic [4:0] p, input logic [4:0] a, output logic [15:0] d);
    go(1'b0, p, a, 16'h0000);
    d = (mgmt_resp.valid === 1'b1) ? mgmt_resp.data : 16'hxxxx;
  endtask
endmodule

`default_nettype wire

/* sim/ext_regs_checker.sv */
// Concurrent checks on the ports of the extended register bank.
// Assumes at least two ports; port 0 and port 1 are watched closely.
`timescale 1ns/1ps
`default_nettype none

`include "ext_ctrl_defines.svh"

module ext_regs_checker #(
  parameter int NUM_PORTS = 4,
  parameter int BASE_PHY_ADDR = 0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Management side
  input wire ext_ctrl_pkg::mgmt_req_t mgmt_req,
  input wire ext_ctrl_pkg::mgmt_resp_t mgmt_resp,
  // Port side
  input wire logic [NUM_PORTS-1:0] soft_reset,
  input wire ext_ctrl_pkg::line_status_t [NUM_PORTS-1:0] line_status,
  input wire ext_ctrl_pkg::port_ctrl_t [NUM_PORTS-1:0] port_ctrl,
  input wire logic [NUM_PORTS-1:0] link_pass,
  input wire logic [NUM_PORTS-1:0] carrier_sense,
  input wire logic [NUM_PORTS-1:0] fwd_wr_mask,
  input wire logic [4:0] fwd_reg_addr,
  input wire logic [15:0] fwd_wdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  logic any_bcast;
  logic rd22_1;
  logic ev1;
  always_comb begin
    any_bcast = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      any_bcast = any_bcast | port_ctrl[i].broadcast_write;
    end
  end
  assign rd22_1 = mgmt_req.rd && mgmt_req.reg_addr == `ADDR_EXT_CTRL_STATUS && mgmt_req.phy == 5'(BASE_PHY_ADDR + 1);
  assign ev1 = line_status[1].eof_error | line_status[1].disconnect;

  property p_answer;
    mgmt_req.rd |=> mgmt_resp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_link;
    1'b1 |=> link_pass[0] == $past(line_status[0].link_active | port_ctrl[0].force_link);
  endproperty
  a_link: assert property (p_link) else $error("link pass wrong");
  property p_hd;
    !line_status[0].full_duplex && !port_ctrl[0].cs_mode[1] |=>
      carrier_sense[0] == $past(line_status[0].rx_active | line_status[0].tx_active);
  endproperty
  a_hd: assert property (p_hd) else $error("half duplex carrier sense wrong");
  property p_fd_none;
    line_status[0].full_duplex && port_ctrl[0].cs_mode[0] |=> !carrier_sense[0];
  endproperty
  a_fd_none: assert property (p_fd_none) else $error("full duplex carrier sense not off");
  property p_bcast;
    mgmt_req.wr && any_bcast |=> fwd_wr_mask == {NUM_PORTS{1'b1}};
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast write not to all ports");
  property p_single;
    mgmt_req.wr && !any_bcast && mgmt_req.phy == 5'(BASE_PHY_ADDR) |=> fwd_wr_mask == NUM_PORTS'(1);
  endproperty
  a_single: assert property (p_single) else $error("single write mask wrong");
  property p_fwd;
    1'b1 |=> fwd_wdata == $past(mgmt_req.wdata) && fwd_reg_addr == $past(mgmt_req.reg_addr);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded write wrong");
  property p_flag;
    line_status[1].eof_error ##1 rd22_1 |=> mgmt_resp.data[8];
  endproperty
  a_flag: assert property (p_flag) else $error("frame error flag missing");
  property p_clear;
    (rd22_1 && !ev1) ##1 !ev1 ##1 (rd22_1 && !ev1) |=> mgmt_resp.data[8:7] == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared by read");
  property p_default;
    soft_reset[1] && !mgmt_req.wr && !port_ctrl[1].retain_sticky |=>
      {port_ctrl[1].force_link, port_ctrl[1].jabber_disable, port_ctrl[1].echo_disable,
       port_ctrl[1].heartbeat_test_disable, port_ctrl[1].squelch, port_ctrl[1].cs_mode,
       port_ctrl[1].broadcast_write} == 9'h060;
  endproperty
  a_default: assert property (p_default) else $error("sticky bits not defaulted");
  property p_super;
    soft_reset[1] && !mgmt_req.wr |=> $stable(port_ctrl[1].retain_sticky) &&
      $stable(port_ctrl[1].mac_mode_1000x) && $stable(port_ctrl[1].mac_aneg_enable);
  endproperty
  a_super: assert property (p_super) else $error("super-sticky bit changed");

  c_bcast: cover property (mgmt_req.wr && any_bcast);
  c_soft: cover property (soft_reset[1] && !port_ctrl[1].retain_sticky);
  c_flag: cover property (line_status[1].eof_error ##1 rd22_1);
endmodule

bind phy_ext_regs ext_regs_checker #(.NUM_PORTS(NUM_PORTS), .BASE_PHY_ADDR(BASE_PHY_ADDR)) u_chk (
  .clock, .resetn, .mgmt_req, .mgmt_resp, .soft_reset, .line_status,
  .port_ctrl, .link_pass, .carrier_sense, .fwd_wr_mask, .fwd_reg_addr, .fwd_wdata);

`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the extended register bank with four ports.
// Assumes the station model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {logic [4:0] phy; logic [4:0] ra; logic [15:0] wd; logic [15:0] ex;} row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] sr = 4'h0;
  logic strap = 1'b1;
  ext_ctrl_pkg::line_status_t [3:0] ls = '0;
  ext_ctrl_pkg::mgmt_req_t req;
  ext_ctrl_pkg::mgmt_resp_t resp;
  logic [3:0] cs;
  logic [15:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  row_t rows [7] = '{'{5'h00, 5'h16, 16'hfffe, 16'hfe46}, '{5'h00, 5'h16, 16'h0c38, 16'h0c00},
    '{5'h00, 5'h16, 16'h8000, 16'h8040}, '{5'h00, 5'h16, 16'h0000, 16'h0000},
    '{5'h00, 5'h17, 16'hffff, 16'h3000}, '{5'h00, 5'h15, 16'hffff, 16'h0000},
    '{5'h09, 5'h16, 16'hffff, 16'h0000}};

  always #12.5 clock = ~clock;

  phy_ext_regs u_dut (.clock(clock), .resetn(resetn), .mgmt_req(req), .mgmt_resp(resp),
    .soft_reset(sr), .line_status(ls), .config_strap_mode(strap), .port_ctrl(), .link_pass(),
    .carrier_sense(cs), .fwd_wr_mask(), .fwd_reg_addr(), .fwd_wdata());
  mgmt_station u_sta (.clock(clock), .mgmt_req(req), .mgmt_resp(resp));

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic rdchk(input logic [4:0] p, input logic [4:0] a, input logic [15:0] exp);
    u_sta.rd_reg(p, a, rd);
    chk16(rd, exp);
  endtask

  // Event pulses last one cycle; the clearing runs alongside the next request.
  task automatic pulse(input int p);
    ls[p].eof_error = 1'b1;
    ls[p].disconnect = 1'b1;
    fork
      begin
        @(posedge clock);
        #1 ls[p] = '0;
      end
    join_none
  endtask

  task automatic sreset(input int p);
    @(posedge clock);
    #1 sr[p] = 1'b1;
    @(posedge clock);
    #1 sr[p] = 1'b0;
  endtask

  function automatic logic cs_exp(input logic [1:0] m, input logic fd, input logic rx, input logic tx);
    if (fd) return rx & ~m[0];
    return m[1] ? rx : (rx | tx);
  endfunction

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  // The whole sequence needs under 1500 cycles; the watchdog allows about 4000.
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clock);
    #1 resetn = 1'b1;
    // The strap load lands a few edges after release, so the first request waits.
    repeat (8) @(posedge clock);
    #1;
    rdchk(5'h00, 5'h16, 16'h3200);
    rdchk(5'h00, 5'h17, 16'h2000);
    foreach (rows[i]) begin
      u_sta.wr_reg(rows[i].phy, rows[i].ra, rows[i].wd);
      rdchk(rows[i].phy, rows[i].ra, rows[i].ex);
    end
    for (int m = 0; m < 4; m++) begin
      u_sta.wr_reg(5'h00, 5'h16, 16'(m << 1));
      for (int k = 0; k < 8; k++) begin
        ls[0].full_duplex = k[2];
        ls[0].rx_active = k[1];
        ls[0].tx_active = k[0];
        repeat (2) @(posedge clock);
        #1 chk1(cs[0], cs_exp(m[1:0], k[2], k[1], k[0]));
      end
    end
    ls[0] = '0;
    pulse(1);
    rdchk(5'h01, 5'h16, 16'h3380);
    rdchk(5'h01, 5'h16, 16'h3200);
    u_sta.wr_reg(5'h00, 5'h16, 16'h0001);
    u_sta.wr_reg(5'h02, 5'h16, 16'h8001);
    rdchk(5'h03, 5'h16, 16'h8041);
    pulse(2);
    rdchk(5'h03, 5'h16, 16'h8041);
    u_sta.wr_reg(5'h01, 5'h16, 16'h0000);
    u_sta.wr_reg(5'h01, 5'h16, 16'h4000);
    rdchk(5'h02, 5'h16, 16'h0180);
    rdchk(5'h01, 5'h16, 16'h4000);
    u_sta.wr_reg(5'h01, 5'h16, 16'h4200);
    sreset(1);
    rdchk(5'h01, 5'h16, 16'h4200);
    u_sta.wr_reg(5'h01, 5'h16, 16'h4000);
    u_sta.wr_reg(5'h01, 5'h17, 16'h1000);
    sreset(1);
    rdchk(5'h01, 5'h16, 16'h3000);
    rdchk(5'h01, 5'h17, 16'h1000);
    strap = 1'b0;
    resetn = 1'b0;
    repeat (16) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (8) @(posedge clock);
    rdchk(5'h00, 5'h17, 16'h0000);
    rdchk(5'h02, 5'h16, 16'h3200);
    wrap_up();
  end
endmodule

`default_nettype wire
